// ---- pkg/asr_params.svh ----
// Purpose: Offsets, field positions, reset values and counts of the serial port status and data registers.
// Assumes: Byte-wide register port with a 3-bit register index.
// Notes: Definitions only.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

`define ASR_ADDR_W 3
`define ASR_OFF_STATUS_ONE 3'h0
`define ASR_OFF_STATUS_TWO 3'h1
`define ASR_OFF_DATA_HIGH 3'h2
`define ASR_OFF_DATA_LOW 3'h3
`define ASR_OFF_CONTROL 3'h4

`define ASR_S1_RX_FULL 5
`define ASR_S1_LINE_QUIET 4
`define ASR_S1_OVERRUN 3
`define ASR_S1_NOISE 2
`define ASR_S1_FRAMING 1
`define ASR_S1_PARITY 0

`define ASR_S2_TX_INVERT 4
`define ASR_S2_RX_INVERT 3
`define ASR_S2_LONG_BREAK 2
`define ASR_S2_SW_TX_OUTPUT 1
`define ASR_S2_RX_ACTIVE 0

`define ASR_DH_RX_NINTH 7
`define ASR_DH_TX_NINTH 6

`define ASR_CT_PARITY_TYPE 0
`define ASR_CT_PARITY_ENABLE 1
`define ASR_CT_NINE_BIT 2
`define ASR_CT_WAKEUP 3
`define ASR_CT_SINGLE_WIRE 4
`define ASR_CT_INFRARED 5

`define ASR_RESET_BYTE 8'h00
`define ASR_BREAK_SHORT_8 4'hA
`define ASR_BREAK_SHORT_9 4'hB
`define ASR_BREAK_LONG_8 4'hD
`define ASR_BREAK_LONG_9 4'hE

`endif

// ---- pkg/asr_pkg.sv ----
// Purpose: Types shared by the serial port status and data register block.
// Assumes: Receiver and transmitter cores run on the same clock as this block.
// Notes: Holds types only; numbers live in asr_params.svh.
package asr_pkg;

   // One-cycle report from the receiver core when a frame or line event completes.
   typedef struct packed {
      logic frameDone;
      logic [8:0] frameData;
      logic noise;
      logic stopBit;
      logic startZero;
      logic idleSeen;
   } asr_rx_ev_t;

   // Character handed to the transmit shifter on a data_low write.
   typedef struct packed {
      logic load;
      logic [8:0] data;
   } asr_tx_cmd_t;

   typedef struct packed {
      logic nineBit;
      logic parityEnable;
      logic parityType;
      logic receiverWakeup;
      logic singleWire;
      logic infrared;
      logic longBreak;
      logic [3:0] breakBits;
   } asr_cfg_t;

   typedef struct packed {
      logic rxSync1;
      logic rxSync2;
      logic rxLine;
      logic txPin;
      logic txPinOe_n;
      logic rxFull;
      logic lineQuiet;
      logic idleArmed;
      logic overrun;
      logic noise;
      logic framing;
      logic parity;
      logic [5:0] seen;
      logic rxActive;
      logic txInvert;
      logic rxInvert;
      logic longBreak;
      logic swTxOutput;
      asr_cfg_t cfg;
      logic rxNinth;
      logic [7:0] rxByte;
      logic txNinth;
      asr_tx_cmd_t tx;
      logic [7:0] rdData;
   } asr_state_t;

endpackage : asr_pkg

// ---- src/asr_serial_regs.sv ----
// Purpose: Receive error flags, polarity and line control, and data registers of an asynchronous serial port.
// Assumes: Receiver core, transmit shifter and infrared encoder sit outside on clk_sys.
// Notes: Register reads answer one cycle after the read strobe; the port never stalls.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "asr_params.svh"

// Functional notes
// - A frame completing while data is unread sets the overrun flag at its stop bit.
// - An overrun frame is dropped; received byte and ninth bit stay unchanged.
// - Overrun clears only after a status_one read that saw it, then data_low read.
// - Noise flag sets together with the full flag, never on an overrun frame.
// - A zero stop bit sets framing error with the full flag, not on overrun.
// - While framing error stands, no further frames are taken.
// - With parity enabled, a parity mismatch sets parity error with the full flag.
// - Noise, framing and parity flags clear by status_one read then data_low read.
// - With receiver wakeup set, idle line does not set the line quiet flag.
// - Overrun may read set with full clear and waits for a later clear sequence.
// - Plain format: tx_invert 0 sends one as mark; 1 inverts both levels.
// - Infrared: normal polarity sends high pulse for zero, idles low; inverted opposite.
// - Rx_invert selects expected receive polarity in both formats.
// - Break lasts 10 or 11 bits, or 13 or 14 with long_break_select.
// - In single-wire mode only, single_wire_tx_output sets the transmit pin direction.
// - Rx active sets on a zero in the first sample slot, clears on idle.
// - In nine-bit format the ninth received bit shows at data_high bit 7.
// - Tx ninth bit at data_high bit 6 goes with every nine-bit frame until rewritten.
// - Data_low reads the received byte, writes the transmit byte; rx ninth is read-only.
// - Nine-bit select chooses eight-bit or nine-bit characters.
// - Full flag sets when a frame enters the data register, clears by status then data read.
module asr_serial_regs (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`ASR_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire asr_pkg::asr_rx_ev_t rxEv,
   input wire logic txRaw,
   input wire logic txIrPulse,
   input wire logic rxPinIn,
   output logic rxLine,
   output logic txPinOut,
   output logic txPinOe_n,
   output logic rxInhibit,
   output asr_pkg::asr_tx_cmd_t txCmd,
   output asr_pkg::asr_cfg_t cfg
);
   import asr_pkg::*;

   asr_state_t st_r;
   asr_state_t st_nxt;

   // Parity over the character width; the parity bit itself is the top data bit.
   function automatic logic asr_frame_parity(input logic [8:0] d, input logic nine);
      asr_frame_parity = nine ? (^d) : (^d[7:0]);
   endfunction : asr_frame_parity

   function automatic logic [3:0] asr_break_len(input logic longBrk, input logic nine);
      if (longBrk) begin
         asr_break_len = nine ? `ASR_BREAK_LONG_9 : `ASR_BREAK_LONG_8;
      end else begin
         asr_break_len = nine ? `ASR_BREAK_SHORT_9 : `ASR_BREAK_SHORT_8;
      end
   endfunction : asr_break_len

   logic wrS2;
   logic wrDh;
   logic wrDl;
   logic wrCt;
   logic rdS1;
   logic rdDl;
   logic frameTake;

   assign wrS2 = regWr && (regAddr == `ASR_OFF_STATUS_TWO);
   assign wrDh = regWr && (regAddr == `ASR_OFF_DATA_HIGH);
   assign wrDl = regWr && (regAddr == `ASR_OFF_DATA_LOW);
   assign wrCt = regWr && (regAddr == `ASR_OFF_CONTROL);
   assign rdS1 = regRd && (regAddr == `ASR_OFF_STATUS_ONE);
   assign rdDl = regRd && (regAddr == `ASR_OFF_DATA_LOW);
   // A standing framing error locks out the receiver path until it is cleared.
   assign frameTake = rxEv.frameDone && !st_r.framing;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tx.load = 1'b0;

      // Receive pin crosses in from outside; only the second stage is used.
      st_nxt.rxSync1 = rxPinIn;
      st_nxt.rxSync2 = st_r.rxSync1;
      st_nxt.rxLine = st_r.rxSync2 ^ st_r.rxInvert;

      if (st_r.cfg.infrared) begin
         // A pulse from the encoder marks a zero bit; idle level follows the invert bit.
         st_nxt.txPin = txIrPulse ^ st_r.txInvert;
      end else begin
         st_nxt.txPin = txRaw ^ st_r.txInvert;
      end
      st_nxt.txPinOe_n = st_r.cfg.singleWire ? !st_r.swTxOutput : 1'b0;

      // Software writes; status_one and the flag positions take none.
      if (wrS2) begin
         st_nxt.txInvert = regWrData[`ASR_S2_TX_INVERT];
         st_nxt.rxInvert = regWrData[`ASR_S2_RX_INVERT];
         st_nxt.longBreak = regWrData[`ASR_S2_LONG_BREAK];
         st_nxt.swTxOutput = regWrData[`ASR_S2_SW_TX_OUTPUT];
      end
      if (wrDh) begin
         st_nxt.txNinth = regWrData[`ASR_DH_TX_NINTH];
      end
      if (wrDl) begin
         // The ninth bit is whatever data_high last held, so it must be written first.
         st_nxt.tx.load = 1'b1;
         st_nxt.tx.data = {st_r.txNinth, regWrData};
      end
      if (wrCt) begin
         st_nxt.cfg.parityType = regWrData[`ASR_CT_PARITY_TYPE];
         st_nxt.cfg.parityEnable = regWrData[`ASR_CT_PARITY_ENABLE];
         st_nxt.cfg.nineBit = regWrData[`ASR_CT_NINE_BIT];
         st_nxt.cfg.receiverWakeup = regWrData[`ASR_CT_WAKEUP];
         st_nxt.cfg.singleWire = regWrData[`ASR_CT_SINGLE_WIRE];
         st_nxt.cfg.infrared = regWrData[`ASR_CT_INFRARED];
      end
      st_nxt.cfg.longBreak = st_nxt.longBreak;
      st_nxt.cfg.breakBits = asr_break_len(st_nxt.longBreak, st_nxt.cfg.nineBit);

      // Flag clearing first, so that a set in the same cycle wins.
      if (rdDl) begin
         if (st_r.seen[`ASR_S1_RX_FULL]) st_nxt.rxFull = 1'b0;
         if (st_r.seen[`ASR_S1_LINE_QUIET]) st_nxt.lineQuiet = 1'b0;
         if (st_r.seen[`ASR_S1_OVERRUN]) st_nxt.overrun = 1'b0;
         if (st_r.seen[`ASR_S1_NOISE]) st_nxt.noise = 1'b0;
         if (st_r.seen[`ASR_S1_FRAMING]) st_nxt.framing = 1'b0;
         if (st_r.seen[`ASR_S1_PARITY]) st_nxt.parity = 1'b0;
         st_nxt.seen = 6'h00;
      end
      // A status read arms only the flags it saw; a flag raised later needs a fresh read.
      if (rdS1) begin
         st_nxt.seen = {st_r.rxFull, st_r.lineQuiet, st_r.overrun, st_r.noise, st_r.framing, st_r.parity};
      end

      if (frameTake) begin
         // Full is judged before any same-cycle data read, so a coincident read still overruns.
         if (st_r.rxFull) begin
            st_nxt.overrun = 1'b1;
         end else begin
            st_nxt.rxFull = 1'b1;
            st_nxt.idleArmed = 1'b1;
            st_nxt.rxByte = rxEv.frameData[7:0];
            st_nxt.rxNinth = st_r.cfg.nineBit ? rxEv.frameData[8] : 1'b0;
            if (rxEv.noise) st_nxt.noise = 1'b1;
            if (!rxEv.stopBit) st_nxt.framing = 1'b1;
            if (st_r.cfg.parityEnable &&
                (asr_frame_parity(rxEv.frameData, st_r.cfg.nineBit) != st_r.cfg.parityType)) begin
               st_nxt.parity = 1'b1;
            end
         end
      end

      if (rxEv.idleSeen) begin
         st_nxt.rxActive = 1'b0;
         // Idle reports only once per received frame, and never while asleep.
         if (st_r.idleArmed && !st_r.cfg.receiverWakeup) begin
            st_nxt.lineQuiet = 1'b1;
            st_nxt.idleArmed = 1'b0;
         end
      end
      if (rxEv.startZero) begin
         st_nxt.rxActive = 1'b1;
      end

      // Read data stands only in the cycle after the strobe.
      st_nxt.rdData = 8'h00;
      if (regRd) begin
         case (regAddr)
            `ASR_OFF_STATUS_ONE: begin
               st_nxt.rdData = {2'b00, st_r.rxFull, st_r.lineQuiet, st_r.overrun, st_r.noise,
                                st_r.framing, st_r.parity};
            end
            `ASR_OFF_STATUS_TWO: begin
               st_nxt.rdData = {3'b000, st_r.txInvert, st_r.rxInvert, st_r.longBreak,
                                st_r.swTxOutput, st_r.rxActive};
            end
            `ASR_OFF_DATA_HIGH: begin
               st_nxt.rdData = {st_r.rxNinth, st_r.txNinth, 6'h00};
            end
            `ASR_OFF_DATA_LOW: begin
               st_nxt.rdData = st_r.rxByte;
            end
            `ASR_OFF_CONTROL: begin
               st_nxt.rdData = {2'b00, st_r.cfg.infrared, st_r.cfg.singleWire, st_r.cfg.receiverWakeup,
                                st_r.cfg.nineBit, st_r.cfg.parityEnable, st_r.cfg.parityType};
            end
            default: begin
               st_nxt.rdData = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         // Idle line levels: receive idles at mark, transmit idles at mark.
         st_r.rxSync1 <= 1'b1;
         st_r.rxSync2 <= 1'b1;
         st_r.rxLine <= 1'b1;
         st_r.txPin <= 1'b1;
         st_r.rxByte <= `ASR_RESET_BYTE;
         st_r.cfg.breakBits <= `ASR_BREAK_SHORT_8;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdData = st_r.rdData;
   assign rxLine = st_r.rxLine;
   assign txPinOut = st_r.txPin;
   assign txPinOe_n = st_r.txPinOe_n;
   assign rxInhibit = st_r.framing;
   assign txCmd = st_r.tx;
   assign cfg = st_r.cfg;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_overrun_set;
      frameTake && st_r.rxFull |=> st_r.overrun && st_r.rxFull;
   endproperty
   a_overrun_set: assert property (p_overrun_set) else $error("Overrun not raised on frame into full register.");

   property p_overrun_keeps_data;
      frameTake && st_r.rxFull |=> $stable(st_r.rxByte) && $stable(st_r.rxNinth) && !$rose(st_r.noise);
   endproperty
   a_overrun_keeps_data: assert property (p_overrun_keeps_data) else $error("Overrun frame disturbed held data.");

   property p_overrun_clear;
      $fell(st_r.overrun) |-> $past(rdDl) && $past(st_r.seen[`ASR_S1_OVERRUN]);
   endproperty
   a_overrun_clear: assert property (p_overrun_clear) else $error("Overrun cleared without status then data read.");

   property p_noise_with_full;
      $rose(st_r.noise) |-> $rose(st_r.rxFull);
   endproperty
   a_noise_with_full: assert property (p_noise_with_full) else $error("Noise flag set apart from full flag.");

   property p_framing_set;
      frameTake && !st_r.rxFull && !rxEv.stopBit |=> st_r.framing && rxInhibit;
   endproperty
   a_framing_set: assert property (p_framing_set) else $error("Zero stop bit did not raise framing error.");

   property p_framing_blocks;
      st_r.framing && rxEv.frameDone |=> $stable(st_r.rxByte) && !$rose(st_r.overrun);
   endproperty
   a_framing_blocks: assert property (p_framing_blocks) else $error("Frame taken while framing error stood.");

   property p_parity_needs_enable;
      $rose(st_r.parity) |-> $past(st_r.cfg.parityEnable) && $rose(st_r.rxFull);
   endproperty
   a_parity_needs_enable: assert property (p_parity_needs_enable) else $error("Parity error without enable.");

   property p_quiet_wakeup;
      $rose(st_r.lineQuiet) |-> !$past(st_r.cfg.receiverWakeup) && $past(rxEv.idleSeen);
   endproperty
   a_quiet_wakeup: assert property (p_quiet_wakeup) else $error("Line quiet set during wakeup.");

   property p_nrz_polarity;
      !st_r.cfg.infrared ##1 !st_r.cfg.infrared |-> txPinOut == ($past(txRaw) ^ $past(st_r.txInvert));
   endproperty
   a_nrz_polarity: assert property (p_nrz_polarity) else $error("Transmit pin level wrong.");

   property p_pin_dir;
      !st_r.cfg.singleWire |=> !txPinOe_n;
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("Transmit pin released outside single-wire mode.");

   property p_active_set;
      rxEv.startZero |=> st_r.rxActive ##1 (st_r.rxActive || $past(rxEv.idleSeen));
   endproperty
   a_active_set: assert property (p_active_set) else $error("Rx active not set on start zero.");

   property p_tx_load;
      wrDl |=> txCmd.load && txCmd.data == {$past(st_r.txNinth), $past(regWrData)} ##1 (!txCmd.load || $past(wrDl));
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("Transmit character not issued.");

   property p_full_set;
      frameTake && !st_r.rxFull |=> st_r.rxFull && st_r.rxByte == $past(rxEv.frameData[7:0]);
   endproperty
   a_full_set: assert property (p_full_set) else $error("Accepted frame not placed in data register.");

   property p_ninth_bit;
      frameTake && !st_r.rxFull |=> st_r.rxNinth == ($past(st_r.cfg.nineBit) && $past(rxEv.frameData[8]));
   endproperty
   a_ninth_bit: assert property (p_ninth_bit) else $error("Received ninth bit wrong.");

   // Noise can only rise on an accepted frame, so without one the armed clear must win.
   property p_noise_clear;
      rdDl && st_r.seen[`ASR_S1_NOISE] && !frameTake |=> !st_r.noise;
   endproperty
   a_noise_clear: assert property (p_noise_clear) else $error("Noise flag survived its clear sequence.");

   property p_overrun_no_flags;
      frameTake && st_r.rxFull |=> !$rose(st_r.framing) && !$rose(st_r.parity);
   endproperty
   a_overrun_no_flags: assert property (p_overrun_no_flags) else $error("Error flag set by overrun frame.");

   property p_active_hold;
      !rxEv.startZero && !rxEv.idleSeen |=> $stable(st_r.rxActive);
   endproperty
   a_active_hold: assert property (p_active_hold) else $error("Rx active changed without line event.");

   property p_rx_polarity;
      !rst |=> rxLine == ($past(st_r.rxSync2) ^ $past(st_r.rxInvert));
   endproperty
   a_rx_polarity: assert property (p_rx_polarity) else $error("Receive line polarity wrong.");

   property p_ir_polarity;
      st_r.cfg.infrared |=> txPinOut == ($past(txIrPulse) ^ $past(st_r.txInvert));
   endproperty
   a_ir_polarity: assert property (p_ir_polarity) else $error("Infrared pin level wrong.");

   property p_break_long;
      st_r.cfg.longBreak |-> (cfg.breakBits == `ASR_BREAK_LONG_8 || cfg.breakBits == `ASR_BREAK_LONG_9);
   endproperty
   a_break_long: assert property (p_break_long) else $error("Long break length wrong.");

   property p_pin_dir_single;
      st_r.cfg.singleWire |=> txPinOe_n == !$past(st_r.swTxOutput);
   endproperty
   a_pin_dir_single: assert property (p_pin_dir_single) else $error("Single-wire pin direction wrong.");

   property p_dl_read;
      regRd && regAddr == `ASR_OFF_DATA_LOW |=> regRdData == $past(st_r.rxByte);
   endproperty
   a_dl_read: assert property (p_dl_read) else $error("Data low read returned wrong byte.");

   property p_ninth_read_only;
      wrDh && !frameTake |=> $stable(st_r.rxNinth);
   endproperty
   a_ninth_read_only: assert property (p_ninth_read_only) else $error("Write changed received ninth bit.");

   // Read data must not linger, or a later poll could see a stale status.
   property p_rdata_idle;
      !regRd |=> regRdData == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data stood past its cycle.");

endmodule : asr_serial_regs
`default_nettype wire

// ---- dv/asr_remote_model.sv ----
// Purpose: Remote serial device as seen through the receiver core's reports and the receive pin.
// Assumes: The receiver core reports on clk_sys; each report stands for exactly one cycle.
// Notes: The receive pin idles at mark until a level is commanded.
`timescale 1ns/100ps
`default_nettype none
module asr_remote_model (
   input wire logic clk_sys,
   output var asr_pkg::asr_rx_ev_t rxEv,
   output logic rxPinIn
);
   import asr_pkg::*;

   initial begin
      rxEv = '0;
      rxPinIn = 1'b1;
   end

   // A stop bit of zero is only sent when a scenario asks for a framing fault.
   task automatic frame(input logic [8:0] d, input logic nz, input logic stp);
      @(posedge clk_sys);
      rxEv <= {1'b1, d, nz, stp, 1'b0, 1'b0};
      @(posedge clk_sys);
      rxEv <= '0;
   endtask : frame

   task automatic line_event(input logic sz, input logic idl);
      @(posedge clk_sys);
      rxEv <= {1'b0, 9'h000, 1'b0, 1'b0, sz, idl};
      @(posedge clk_sys);
      rxEv <= '0;
   endtask : line_event

   task automatic drive_pin(input logic v);
      @(posedge clk_sys);
      rxPinIn <= v;
   endtask : drive_pin
endmodule : asr_remote_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the serial port status and data registers.
// Assumes: Remote device model drives the receiver reports and the receive pin.
// Notes: Random frames come from a fixed seed; flag clearing is checked after every random frame.
`timescale 1ns/100ps
`default_nettype none
`include "asr_params.svh"
module testbench;
   import asr_pkg::*;
   localparam logic [2:0] S1 = `ASR_OFF_STATUS_ONE;
   localparam logic [2:0] S2 = `ASR_OFF_STATUS_TWO;
   localparam logic [2:0] DH = `ASR_OFF_DATA_HIGH;
   localparam logic [2:0] DL = `ASR_OFF_DATA_LOW;
   localparam logic [2:0] CT = `ASR_OFF_CONTROL;
   logic clk_sys, rst, regWr, regRd, txRaw, txIrPulse, rxPinIn, rxLine, txPinOut, txPinOe_n, rxInhibit;
   logic [`ASR_ADDR_W-1:0] regAddr;
   logic [7:0] regWrData, regRdData, a, b;
   logic [8:0] d9;
   logic nz, pe, pt, nine;
   asr_rx_ev_t rxEv;
   asr_tx_cmd_t txCmd;
   asr_cfg_t cfg;
   int mismatches, compares;

   asr_serial_regs i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxEv(rxEv), .txRaw(txRaw),
      .txIrPulse(txIrPulse), .rxPinIn(rxPinIn), .rxLine(rxLine), .txPinOut(txPinOut),
      .txPinOe_n(txPinOe_n), .rxInhibit(rxInhibit), .txCmd(txCmd), .cfg(cfg));
   asr_remote_model i_remote (.clk_sys(clk_sys), .rxEv(rxEv), .rxPinIn(rxPinIn));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      #1;
   endtask : wr

   task automatic rdc(input logic [2:0] ad, input logic [7:0] exp);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      chk({8'h00, regRdData}, {8'h00, exp});
   endtask : rdc

   // Even parity type 0: the XOR over all character bits, parity included, must be zero.
   function automatic logic [7:0] exp_s1(input logic [8:0] d, input logic n, input logic e, input logic t,
      input logic m);
      logic par;
      par = m ? ^d : ^d[7:0];
      return {2'b00, 1'b1, 2'b00, n, 1'b0, e & (par ^ t)};
   endfunction : exp_s1

   task automatic finish_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      finish_test();
   end

   initial begin
      void'($urandom(35));
      rst = 1'b1;
      regAddr = '0;
      regWrData = '0;
      regWr = 1'b0;
      regRd = 1'b0;
      txRaw = 1'b1;
      txIrPulse = 1'b0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(S1, 8'h00);
      rdc(S2, 8'h00);
      rdc(DL, `ASR_RESET_BYTE);
      rdc(3'h7, 8'h00);
      chk(cfg.breakBits, `ASR_BREAK_SHORT_8);
      i_remote.line_event(1'b1, 1'b0);
      rdc(S2, 8'h01);
      i_remote.line_event(1'b0, 1'b1);
      rdc(S2, 8'h00);
      wr(S1, 8'hFF);
      rdc(S1, 8'h00);
      wr(S2, 8'h1F);
      rdc(S2, 8'h1E);
      chk(cfg.breakBits, `ASR_BREAK_LONG_8);
      wr(CT, 8'h04);
      tick(1);
      chk(cfg.breakBits, `ASR_BREAK_LONG_9);
      txRaw <= 1'b1;
      tick(2);
      chk(txPinOut, 1'b0);
      txRaw <= 1'b0;
      tick(2);
      chk(txPinOut, 1'b1);
      chk(txPinOe_n, 1'b0);
      wr(CT, 8'h14);
      tick(2);
      chk(txPinOe_n, 1'b0);
      wr(S2, 8'h1C);
      tick(2);
      chk(txPinOe_n, 1'b1);
      wr(CT, 8'h24);
      txIrPulse <= 1'b1;
      tick(2);
      chk(txPinOut, 1'b0);
      txIrPulse <= 1'b0;
      tick(2);
      chk(txPinOut, 1'b1);
      wr(S2, 8'h0C);
      tick(2);
      chk(txPinOut, 1'b0);
      i_remote.drive_pin(1'b0);
      tick(4);
      chk(rxLine, 1'b1);
      wr(S2, 8'h04);
      tick(4);
      chk(rxLine, 1'b0);
      wr(S2, 8'h0C);
      tick(4);
      chk(rxLine, 1'b1);
      i_remote.drive_pin(1'b1);
      wr(S2, 8'h00);
      wr(CT, 8'h00);
      a = 8'($urandom);
      wr(DH, 8'hC0);
      rdc(DH, 8'h40);
      wr(DL, a);
      chk({6'h00, txCmd}, {6'h00, 1'b1, 1'b1, a});
      tick(1);
      chk(txCmd.load, 1'b0);
      wr(DL, ~a);
      chk({6'h00, txCmd}, {6'h00, 1'b1, 1'b1, ~a});
      for (int i = 0; i < 24; i++) begin
         {nine, pe, pt, nz} = 4'($urandom);
         d9 = 9'($urandom);
         wr(CT, {5'h00, nine, pe, pt});
         i_remote.frame(d9, nz, 1'b1);
         rdc(S1, exp_s1(d9, nz, pe, pt, nine));
         rdc(DH, {nine & d9[8], 7'h40});
         rdc(DL, d9[7:0]);
         rdc(S1, 8'h00);
      end
      a = 8'($urandom);
      b = ~a;
      wr(CT, 8'h04);
      i_remote.frame({1'b1, a}, 1'b0, 1'b1);
      i_remote.frame({1'b0, b}, 1'b1, 1'b0);
      rdc(S1, 8'h28);
      chk(rxInhibit, 1'b0);
      rdc(DH, 8'hC0);
      rdc(DL, a);
      rdc(S1, 8'h00);
      i_remote.frame({1'b0, a}, 1'b0, 1'b1);
      rdc(S1, 8'h20);
      i_remote.frame({1'b0, b}, 1'b0, 1'b1);
      rdc(DL, a);
      rdc(S1, 8'h08);
      rdc(DL, a);
      rdc(S1, 8'h00);
      i_remote.frame({1'b0, a}, 1'b0, 1'b0);
      rdc(S1, 8'h22);
      chk(rxInhibit, 1'b1);
      i_remote.frame({1'b0, b}, 1'b0, 1'b1);
      rdc(DL, a);
      rdc(S1, 8'h00);
      chk(rxInhibit, 1'b0);
      i_remote.frame({1'b0, b}, 1'b0, 1'b1);
      i_remote.line_event(1'b0, 1'b1);
      rdc(S1, 8'h30);
      rdc(DL, b);
      rdc(S1, 8'h00);
      wr(CT, 8'h08);
      i_remote.frame({1'b0, a}, 1'b0, 1'b1);
      i_remote.line_event(1'b0, 1'b1);
      rdc(S1, 8'h20);
      rdc(DL, a);
      finish_test();
   end
endmodule : testbench
`default_nettype wire
